// ==== core/hsc_link.sv ====
/*
  Link end: runs the chirp detection handshake from idle or from suspend,
  generates the device chirp, validates host chirps, and offers control
  and status registers on APB.
  Assumes pclk stands for the transceiver output clock and that the
  clock is usable whenever the transceiver reports it so.
*/
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module hsc_link #(
  parameter logic [hsc_pkg::CNT_W-1:0] CHIRP_CYCLES = hsc_pkg::CHIRP_CYCLES_DEF,
  parameter logic [hsc_pkg::CNT_W-1:0] NO_CHIRP_CYCLES = hsc_pkg::NO_CHIRP_CYCLES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  hsc_utmi_if.link utmi,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hsc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import hsc_pkg::*;

  hsc_state_type state;
  logic [CNT_W-1:0] timer;
  logic [7:0] run;
  logic [1:0] last_ls;
  logic [2:0] chirp_count;
  logic start_req;
  logic suspend_req;
  logic access;
  logic wake_event;
  logic [1:0] expected_ls;

  assign access = psel && penable && !pready;
  assign wake_event = (state == ST_SUSPEND) && (last_ls == LS_J)
                      && (utmi.linestate == LS_SE0);
  // Released in the same cycle as the wake edge
  assign utmi.suspend_low = (state != ST_SUSPEND) || wake_event;
  assign utmi.tx_data = TX_ZERO;
  assign expected_ls = chirp_count[0] ? LS_J : LS_K;

  // APB slave, one wait cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      start_req <= 1'b0;
      suspend_req <= 1'b0;
    end else begin
      pready <= access;
      start_req <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      if (access) begin
        if (paddr == CTRL_OFFSET) begin
          if (pwrite) begin
            start_req <= pwdata[CTRL_START_BIT];
            suspend_req <= pwdata[CTRL_SUSPEND_BIT];
          end else begin
            prdata[CTRL_SUSPEND_BIT] <= suspend_req;
          end
        end else if (paddr == STATUS_OFFSET) begin
          if (!pwrite) begin
            prdata[STAT_STATE_LSB +: 3] <= state;
            prdata[STAT_COUNT_LSB +: 3] <= chirp_count;
            prdata[STAT_HS_BIT] <= (utmi.term_select == SEL_HS);
            prdata[STAT_CLK_BIT] <= utmi.clock_usable;
          end
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_ls <= LS_SE0;
    end else begin
      last_ls <= utmi.linestate;
    end
  end

  // Handshake sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      timer <= '0;
      utmi.xcvr_select <= SEL_FS;
      utmi.term_select <= SEL_FS;
      utmi.opmode <= OPMODE_NORMAL;
      utmi.tx_valid <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          utmi.xcvr_select <= SEL_FS;
          utmi.term_select <= SEL_FS;
          if (start_req) begin
            // Chirp starts at once, leaving margin for a late start
            state <= ST_CHIRP;
            timer <= '0;
            utmi.opmode <= OPMODE_RAW;
            utmi.xcvr_select <= SEL_HS;
            utmi.tx_valid <= 1'b1;
          end else if (suspend_req) begin
            state <= ST_SUSPEND;
          end
        end
        ST_SUSPEND: begin
          if (wake_event) begin
            state <= ST_WAKE;
          end else if (!suspend_req) begin
            state <= ST_IDLE;
          end
        end
        ST_WAKE: begin
          if (utmi.clock_usable) begin
            state <= ST_CHIRP;
            timer <= '0;
            utmi.opmode <= OPMODE_RAW;
            utmi.xcvr_select <= SEL_HS;
            utmi.tx_valid <= 1'b1;
          end
        end
        ST_CHIRP: begin
          timer <= timer + 1'b1;
          if (timer == CHIRP_CYCLES - 1'b1) begin
            state <= ST_LISTEN;
            timer <= '0;
            utmi.tx_valid <= 1'b0;
            utmi.opmode <= OPMODE_NORMAL;
          end
        end
        ST_LISTEN: begin
          timer <= timer + 1'b1;
          if (chirp_count == CHIRPS_NEEDED) begin
            state <= ST_HS;
            utmi.term_select <= SEL_HS;
          end else if (timer == NO_CHIRP_CYCLES - 1'b1) begin
            state <= ST_FS;
            utmi.xcvr_select <= SEL_FS;
          end
        end
        ST_HS, ST_FS: begin
          if (start_req) begin
            state <= ST_IDLE;
            utmi.xcvr_select <= SEL_FS;
            utmi.term_select <= SEL_FS;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Host chirp filter and counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= '0;
      chirp_count <= '0;
    end else if (state != ST_LISTEN) begin
      run <= '0;
      chirp_count <= '0;
    end else if (utmi.linestate != last_ls) begin
      run <= '0;
      if (run < FILT_CYCLES) begin
        chirp_count <= '0;
      end
    end else if (run < FILT_CYCLES) begin
      run <= run + 1'b1;
      if (run == FILT_CYCLES - 1'b1) begin
        // Steady long enough; must match the alternation
        if (utmi.linestate == expected_ls && chirp_count != CHIRPS_NEEDED) begin
          chirp_count <= chirp_count + 1'b1;
        end else if (chirp_count != CHIRPS_NEEDED) begin
          chirp_count <= '0;
        end
      end
    end
  end
endmodule : hsc_link

// ==== core/hsc_pkg.sv ====
/*
  Shared constants for the chirp detection handshake: line states,
  operating modes, timing counts and the controller's register map.
  Assumes one clock at CLK_HZ standing in for the transceiver output clock.
*/
package hsc_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int CLK_MHZ = CLK_HZ / 1000000;
  localparam int CNT_W = 20;

  // Line state codes
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J = 2'h1;
  localparam logic [1:0] LS_K = 2'h2;

  // Operating modes and select levels
  localparam logic [1:0] OPMODE_NORMAL = 2'h0;
  localparam logic [1:0] OPMODE_RAW = 2'h2;
  localparam logic SEL_HS = 1'b0;
  localparam logic SEL_FS = 1'b1;
  localparam logic [7:0] TX_ZERO = 8'h00;

  // Timing, as printed and as cycle counts
  localparam logic [CNT_W-1:0] CHIRP_CYCLES_DEF = 20'h101D0;
  localparam int FILT_TIME_NS = 2500;
  localparam logic [7:0] FILT_CYCLES = 8'hA5;
  localparam int NO_CHIRP_TIME_US = 2000;
  localparam logic [CNT_W-1:0] NO_CHIRP_CYCLES_DEF = CNT_W'(NO_CHIRP_TIME_US * CLK_MHZ);
  localparam int WAKE_TIME_US = 5000;
  localparam logic [CNT_W-1:0] WAKE_CYCLES_DEF = CNT_W'(WAKE_TIME_US * CLK_MHZ);
  localparam int NOMINAL_TIME_US = 20000;
  localparam logic [CNT_W-1:0] NOMINAL_CYCLES_DEF = CNT_W'(NOMINAL_TIME_US * CLK_MHZ);
  localparam logic [2:0] CHIRPS_NEEDED = 3'h6;

  // Register map
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SUSPEND_BIT = 1;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_COUNT_LSB = 4;
  localparam int STAT_HS_BIT = 8;
  localparam int STAT_CLK_BIT = 9;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SUSPEND = 3'b001,
    ST_WAKE = 3'b010,
    ST_CHIRP = 3'b011,
    ST_LISTEN = 3'b100,
    ST_HS = 3'b101,
    ST_FS = 3'b110
  } hsc_state_type;
endpackage : hsc_pkg

// ==== core/hsc_utmi_if.sv ====
/*
  Transceiver control interface between link and transceiver.
  Assumes both ends are clocked by the same pclk.
*/
`timescale 1ns/100ps
interface hsc_utmi_if;
  logic xcvr_select;
  logic term_select;
  logic [1:0] opmode;
  logic tx_valid;
  logic [7:0] tx_data;
  logic suspend_low;
  logic [1:0] linestate;
  logic clock_usable;

  modport phy (
    input xcvr_select,
    input term_select,
    input opmode,
    input tx_valid,
    input tx_data,
    input suspend_low,
    output linestate,
    output clock_usable
  );

  modport link (
    output xcvr_select,
    output term_select,
    output opmode,
    output tx_valid,
    output tx_data,
    output suspend_low,
    input linestate,
    input clock_usable
  );
endinterface : hsc_utmi_if

// ==== core/hsc_phy.sv ====
/*
  Transceiver end: reports the bus state, drives the chirp K, switches
  pull-up and terminations, and holds the clock unusable after wake-up.
  Assumes the bench models the bus and supplies its line state.
*/
`timescale 1ns/100ps
module hsc_phy #(
  parameter logic [hsc_pkg::CNT_W-1:0] WAKE_CYCLES = hsc_pkg::WAKE_CYCLES_DEF,
  parameter logic [hsc_pkg::CNT_W-1:0] NOMINAL_CYCLES = hsc_pkg::NOMINAL_CYCLES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  hsc_utmi_if.phy utmi,
  input wire logic [1:0] bus_line_state,
  output logic dp_pullup_en,
  output logic hs_term_en,
  output logic chirp_k_drive,
  output logic clock_nominal
);
  import hsc_pkg::*;

  logic [CNT_W-1:0] wake_count;

  // Raw bus state, no debounce
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      utmi.linestate <= LS_SE0;
    end else begin
      utmi.linestate <= bus_line_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dp_pullup_en <= 1'b1;
      hs_term_en <= 1'b0;
    end else begin
      dp_pullup_en <= (utmi.term_select == SEL_FS);
      hs_term_en <= (utmi.term_select == SEL_HS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chirp_k_drive <= 1'b0;
    end else begin
      chirp_k_drive <= (utmi.xcvr_select == SEL_HS) && (utmi.opmode == OPMODE_RAW)
                       && utmi.tx_valid && (utmi.tx_data == TX_ZERO);
    end
  end

  // Oscillator start-up after suspend
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_count <= NOMINAL_CYCLES;
      utmi.clock_usable <= 1'b1;
      clock_nominal <= 1'b1;
    end else if (!utmi.suspend_low) begin
      wake_count <= '0;
      utmi.clock_usable <= 1'b0;
      clock_nominal <= 1'b0;
    end else begin
      if (wake_count < NOMINAL_CYCLES) begin
        wake_count <= wake_count + 1'b1;
      end
      utmi.clock_usable <= (wake_count >= WAKE_CYCLES - 1'b1);
      clock_nominal <= (wake_count >= NOMINAL_CYCLES - 1'b1);
    end
  end
endmodule : hsc_phy

// ==== tb/hsc_utmi_checker.sv ====
/*
  Assertions on the transceiver control signals of the chirp handshake.
  Assumes the bench instantiates it beside the interface joining both ends.
*/
`timescale 1ns/100ps
module hsc_utmi_checker #(
  parameter logic [hsc_pkg::CNT_W-1:0] CHIRP_CYCLES = hsc_pkg::CHIRP_CYCLES_DEF,
  parameter logic [hsc_pkg::CNT_W-1:0] NO_CHIRP_CYCLES = hsc_pkg::NO_CHIRP_CYCLES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic xcvr_select,
  input wire logic term_select,
  input wire logic [1:0] opmode,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic suspend_low,
  input wire logic [1:0] linestate,
  input wire logic clock_usable
);
  import hsc_pkg::*;
  logic [1:0] prev_ls;
  logic [7:0] run_len;
  logic [CNT_W-1:0] chirp_cnt;
  logic [CNT_W-1:0] listen_cnt;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Steady line state length, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ls <= LS_SE0;
      run_len <= 8'h00;
    end else begin
      prev_ls <= linestate;
      if (linestate != prev_ls) begin
        run_len <= 8'h00;
      end else if (run_len != 8'hFF) begin
        run_len <= run_len + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chirp_cnt <= '0;
      listen_cnt <= '0;
    end else begin
      chirp_cnt <= tx_valid ? chirp_cnt + 1'b1 : '0;
      listen_cnt <= (tx_valid || xcvr_select == SEL_FS) ? '0 : listen_cnt + 1'b1;
    end
  end

  property p_chirp_raw;
    tx_valid |-> opmode == OPMODE_RAW && xcvr_select == SEL_HS && tx_data == TX_ZERO;
  endproperty
  a_chirp_raw: assert property (p_chirp_raw)
    else $error("chirp without raw mode, high speed and zero data");
  property p_chirp_entry;
    $rose(tx_valid) |-> $past(term_select) == SEL_FS && $past(xcvr_select) == SEL_FS;
  endproperty
  a_chirp_entry: assert property (p_chirp_entry)
    else $error("chirp begun without full-speed selects");
  property p_chirp_len;
    $fell(tx_valid) |-> chirp_cnt == CHIRP_CYCLES && xcvr_select == SEL_HS;
  endproperty
  a_chirp_len: assert property (p_chirp_len)
    else $error("chirp length wrong");
  property p_filter;
    $fell(term_select) |-> run_len >= 8'hA4 && $past(linestate) == LS_J;
  endproperty
  a_filter: assert property (p_filter)
    else $error("high speed taken without a filtered final J");
  property p_hs_entry;
    $fell(term_select) |-> xcvr_select == SEL_HS && opmode == OPMODE_NORMAL;
  endproperty
  a_hs_entry: assert property (p_hs_entry)
    else $error("terminations switched in wrong mode");
  property p_release;
    !$past(suspend_low) && $past(linestate) == LS_J && linestate == LS_SE0 |-> suspend_low;
  endproperty
  a_release: assert property (p_release)
    else $error("suspend not released on J to SE0");
  property p_wake;
    $rose(suspend_low) |-> !clock_usable [*8] ##[1:30] clock_usable;
  endproperty
  a_wake: assert property (p_wake)
    else $error("clock usable timing wrong after wake");
  property p_chirp_after_wake;
    $rose(clock_usable) |-> ##[1:2] tx_valid;
  endproperty
  a_chirp_after_wake: assert property (p_chirp_after_wake)
    else $error("no chirp after clock became usable");
  property p_no_chirp;
    $rose(xcvr_select) && $past(term_select) == SEL_FS |->
      listen_cnt >= NO_CHIRP_CYCLES - 2 && listen_cnt <= NO_CHIRP_CYCLES + 2;
  endproperty
  a_no_chirp: assert property (p_no_chirp)
    else $error("full-speed fallback at wrong time");

  c_chirp_done: cover property ($fell(tx_valid));
  c_hs_done: cover property ($fell(term_select));
  c_wake: cover property ($rose(suspend_low));
endmodule : hsc_utmi_checker

// ==== tb/tb_top.sv ====
/*
  Testbench: link and transceiver joined by the interface, APB on the
  link, bus line state on the transceiver. Assumes shortened counts.
*/
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  import hsc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] bus_ls = LS_SE0;
  logic dp_pullup;
  logic hs_term;
  logic chirp_k;
  logic clk_nom;
  logic [31:0] rd;
  logic err;
  int err_total = 0;
  int n_tests = 0;
  int len;
  // Shortened counts: chirp and no-chirp for the link and the checker, wake and nominal for the transceiver
  localparam logic [CNT_W-1:0] TB_CHIRP_CYCLES = 20'h00032;
  localparam logic [CNT_W-1:0] TB_NO_CHIRP_CYCLES = 20'h00BB8;
  localparam logic [CNT_W-1:0] TB_WAKE_CYCLES = 20'h00014;
  localparam logic [CNT_W-1:0] TB_NOMINAL_CYCLES = 20'h00028;

  hsc_utmi_if i_hsc_utmi_if ();
  hsc_link #(.CHIRP_CYCLES(TB_CHIRP_CYCLES), .NO_CHIRP_CYCLES(TB_NO_CHIRP_CYCLES)) i_hsc_link (
    .pclk(pclk), .presetn(presetn), .utmi(i_hsc_utmi_if), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  hsc_phy #(.WAKE_CYCLES(TB_WAKE_CYCLES), .NOMINAL_CYCLES(TB_NOMINAL_CYCLES)) i_hsc_phy (
    .pclk(pclk), .presetn(presetn), .utmi(i_hsc_utmi_if), .bus_line_state(bus_ls),
    .dp_pullup_en(dp_pullup), .hs_term_en(hs_term), .chirp_k_drive(chirp_k),
    .clock_nominal(clk_nom));
  hsc_utmi_checker #(.CHIRP_CYCLES(TB_CHIRP_CYCLES), .NO_CHIRP_CYCLES(TB_NO_CHIRP_CYCLES)) i_chk (
    .pclk(pclk), .presetn(presetn), .xcvr_select(i_hsc_utmi_if.xcvr_select),
    .term_select(i_hsc_utmi_if.term_select), .opmode(i_hsc_utmi_if.opmode),
    .tx_valid(i_hsc_utmi_if.tx_valid), .tx_data(i_hsc_utmi_if.tx_data),
    .suspend_low(i_hsc_utmi_if.suspend_low), .linestate(i_hsc_utmi_if.linestate),
    .clock_usable(i_hsc_utmi_if.clock_usable));

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request holds until the edge at which pready is sampled high
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) err_total++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic host(input logic [1:0] s, input int cyc);
    @(posedge pclk);
    bus_ls <= s;
    repeat (cyc - 1) @(posedge pclk);
  endtask : host

  // Waits for the chirp, then counts its cycles
  task automatic chirp_len();
    int n;
    n = 0;
    len = 0;
    while (chirp_k !== 1'b1 && n < 500) begin
      @(negedge pclk);
      n++;
    end
    while (chirp_k === 1'b1 && len < 500) begin
      @(negedge pclk);
      len++;
    end
  endtask : chirp_len

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (40000) @(posedge pclk);
    err_total++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, STATUS_OFFSET, 32'h0);
    `CHK(rd, 32'h00000200)
    @(negedge pclk);
    `CHK({dp_pullup, hs_term, i_hsc_utmi_if.xcvr_select, i_hsc_utmi_if.term_select}, 4'hB)
    apb(1'b0, 12'h008, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    apb(1'b1, STATUS_OFFSET, 32'hFFFFFFFF);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    `CHK({err, rd}, 33'h000000200)
    // Host answers, with a short SE0 breaking the first run
    apb(1'b1, CTRL_OFFSET, 32'h1);
    chirp_len();
    `CHK(len, 50)
    host(LS_K, 200);
    host(LS_J, 200);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    `CHK(rd, 32'h00000224)
    `CHK(i_hsc_utmi_if.linestate, LS_J)
    host(LS_SE0, 50);
    host(LS_K, 200);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    `CHK(rd, 32'h00000214)
    for (int i = 0; i < 5; i++) host(i[0] ? LS_K : LS_J, 200);
    host(LS_SE0, 10);
    @(negedge pclk);
    `CHK({dp_pullup, hs_term}, 2'h1)
    apb(1'b0, STATUS_OFFSET, 32'h0);
    `CHK(rd, 32'h00000305)
    // Silent host: fallback to full speed
    apb(1'b1, CTRL_OFFSET, 32'h1);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    repeat (2000) @(posedge pclk);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    `CHK(rd[3:0], 4'h4)
    repeat (1200) @(posedge pclk);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    `CHK(rd[2:0], 3'h6)
    `CHK(i_hsc_utmi_if.xcvr_select, SEL_FS)
    // Handshake from suspend
    apb(1'b1, CTRL_OFFSET, 32'h1);
    apb(1'b1, CTRL_OFFSET, 32'h2);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    `CHK({rd[9:8], rd[2:0]}, 5'h01)
    @(negedge pclk);
    `CHK(i_hsc_utmi_if.suspend_low, 1'b0)
    host(LS_J, 10);
    host(LS_SE0, 2);
    @(negedge pclk);
    `CHK(i_hsc_utmi_if.suspend_low, 1'b1)
    chirp_len();
    `CHK(len, 50)
    `CHK(clk_nom, 1'b1)
    apb(1'b1, CTRL_OFFSET, 32'h0);
    final_report();
  end
endmodule : tb_top
